// ---- logic/sfrc_core.sv ----
// Summary of operation
// (RQ1) Enabled on-chip SRAM serves low 1 KB
// (RQ2) Addresses above 03FFh go to external bus
// (RQ3) SRAM disabled: all data space is external
// (RQ4) Enable bit sets SRAM; reset clears it
// (RQ5) SFRs at 80-FFh, direct addressing only
// (RQ6) Bit access only at addresses x0, x8
// (RQ7) Unimplemented bits and registers read one
// (RQ8) Select bit 0 picks active pointer pair
// (RQ9) Select bits 1-7 read zero
// (RQ10) Second pointer bytes are plain storage too
// (RQ11) Opcode A5h decrements active pointer
// (RQ12) Baud-double bit doubles serial baud rate
// (RQ13) Frame-error select makes bit 7 error flag
// (RQ14) Two free user flags, no side effects
// (RQ15) Power-down stops all clocks
// (RQ16) Idle stops CPU clock, peripherals run
// (RQ17) Economy mode divides clock by 4/64/1024
// (RQ18) Scratchpad and on-chip SRAM never alias
// (RQ19) Port 0 pull-ups only when enable bit set
// (RQ20) On-chip accesses take two machine cycles
// (RQ21) Power-down and idle together mean power-down
`timescale 1ns/100ps
`default_nettype none
`include "sfrc_cfg.svh"
module sfrc_core
	import sfrc_pkg::*;
#(
	parameter int SRAM_BYTES = 1024,
	parameter int SRAM_AW = 10
) (
	input wire logic clock,
	input wire logic rst,
	input wire sfrc_sfr_req_t sfr_req,
	input wire logic sfr_other_hit,
	input wire logic [7:0] sfr_other_rdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	output logic sfr_bit_ok,
	input wire sfrc_ptr_op_t ptr_op,
	output logic [15:0] active_data_pointer,
	input wire sfrc_mem_req_t mem_req,
	output logic mem_onchip,
	output logic mem_done,
	output logic [7:0] mem_rdata,
	output sfrc_mem_req_t ext_req,
	input wire logic ext_done,
	input wire logic [7:0] ext_rdata,
	input wire logic wake_event,
	output logic cpu_clock_en,
	output logic periph_clock_en,
	output logic power_down_active,
	output logic idle_active,
	output logic baud_double,
	output logic frame_error_select,
	output logic port0_pullup_enable,
	output logic [7:0] port0_latch_q,
	output logic [7:0] stack_pointer_q,
	output logic [7:0] timer_control_q
);
	localparam logic [4:0] ONCHIP_CLKS =
		5'(`SFRC_ONCHIP_MC * `SFRC_CLKS_PER_MC);

	typedef enum logic [1:0] {
		SFRC_M_IDLE,
		SFRC_M_ONCHIP,
		SFRC_M_EXTERN
	} sfrc_mstate_t;

	logic [7:0] port0_latch;
	logic [7:0] stack_pointer;
	logic [7:0] pointer_a_low;
	logic [7:0] pointer_a_high;
	logic [7:0] pointer_b_low;
	logic [7:0] pointer_b_high;
	logic [7:0] pointer_select;
	logic [7:0] power_control;
	logic [7:0] timer_control;
	logic [7:0] power_management_reg;
	logic [7:0] port4_chipselect_input_reg;

	logic sfr_access;
	logic bit_capable;
	logic wr_en;
	logic [7:0] cur_byte;
	logic [7:0] wr_byte;
	logic [7:0] own_rdata;
	logic own_hit;

	// Direct addressing in the upper half only
	assign sfr_access = sfr_req.direct &&
		sfr_req.addr[`SFRC_SFR_SPACE_MSB]; // see RQ5
	assign bit_capable = (sfr_req.addr[2:0] == 3'h0); // see RQ6
	assign sfr_bit_ok = sfr_access && bit_capable;
	assign wr_en = sfr_access && sfr_req.wr &&
		(!sfr_req.bit_op || bit_capable); // see RQ6

	always_comb begin
		own_hit = 1'b1;
		unique case (sfr_req.addr)
			`SFRC_ADDR_PORT0: own_rdata = port0_latch;
			`SFRC_ADDR_STACK: own_rdata = stack_pointer;
			`SFRC_ADDR_PTR_A_LOW: own_rdata = pointer_a_low;
			`SFRC_ADDR_PTR_A_HIGH: own_rdata = pointer_a_high;
			`SFRC_ADDR_PTR_B_LOW: own_rdata = pointer_b_low;
			`SFRC_ADDR_PTR_B_HIGH: own_rdata = pointer_b_high;
			`SFRC_ADDR_PTR_SELECT:
				own_rdata = pointer_select & `SFRC_PSEL_IMPL; // see RQ9
			`SFRC_ADDR_POWER_CTL:
				own_rdata = power_control | ~`SFRC_PCTL_IMPL; // see RQ7
			`SFRC_ADDR_TIMER_CTL: own_rdata = timer_control;
			`SFRC_ADDR_PORT4_CSIN:
				own_rdata = port4_chipselect_input_reg |
					~`SFRC_P4CS_IMPL; // see RQ7
			`SFRC_ADDR_POWER_MGMT:
				own_rdata = power_management_reg |
					~`SFRC_PMGT_IMPL; // see RQ7
			default: begin
				own_hit = 1'b0;
				own_rdata = `SFRC_UNIMPL_BYTE; // see RQ7
			end
		endcase
	end

	assign cur_byte = own_hit ? own_rdata : `SFRC_UNIMPL_BYTE;

	// Single-bit writes merge into the current byte
	always_comb begin
		wr_byte = sfr_req.wdata;
		if (sfr_req.bit_op) begin
			wr_byte = cur_byte;
			wr_byte[sfr_req.bit_sel] = sfr_req.wdata[0];
		end
	end

	always_comb begin
		sfr_hit = sfr_access && (own_hit || sfr_other_hit);
		if (!sfr_access)
			sfr_rdata = `SFRC_RST_ZERO;
		else if (own_hit)
			sfr_rdata = own_rdata;
		else if (sfr_other_hit)
			sfr_rdata = sfr_other_rdata;
		else
			sfr_rdata = `SFRC_UNIMPL_BYTE; // see RQ7
	end

	// Plain storage registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			port0_latch <= `SFRC_RST_PORT0;
			stack_pointer <= `SFRC_RST_STACK;
			timer_control <= `SFRC_RST_ZERO;
			port4_chipselect_input_reg <= `SFRC_RST_ZERO;
			power_management_reg <= `SFRC_RST_ZERO; // see RQ4
		end else if (wr_en) begin
			unique case (sfr_req.addr)
				`SFRC_ADDR_PORT0: port0_latch <= wr_byte;
				`SFRC_ADDR_STACK: stack_pointer <= wr_byte;
				`SFRC_ADDR_TIMER_CTL: timer_control <= wr_byte;
				`SFRC_ADDR_PORT4_CSIN:
					port4_chipselect_input_reg <= wr_byte & `SFRC_P4CS_IMPL;
				`SFRC_ADDR_POWER_MGMT:
					power_management_reg <= wr_byte & `SFRC_PMGT_IMPL;
				default: ;
			endcase
		end
	end

	assign port0_pullup_enable =
		port4_chipselect_input_reg[`SFRC_P4CS_PULLUP]; // see RQ19
	assign port0_latch_q = port0_latch;
	assign stack_pointer_q = stack_pointer;
	assign timer_control_q = timer_control;

	// Data pointers
	logic use_b;
	logic [15:0] next_ptr;
	logic ptr_upd;

	assign use_b = pointer_select[`SFRC_PSEL_BIT]; // see RQ8
	assign active_data_pointer = use_b ?
		{pointer_b_high, pointer_b_low} :
		{pointer_a_high, pointer_a_low}; // see RQ8

	always_comb begin
		ptr_upd = 1'b1;
		next_ptr = active_data_pointer;
		if (ptr_op.load)
			next_ptr = ptr_op.value;
		else if (ptr_op.op_valid && ptr_op.opcode == `SFRC_OPC_PTR_DEC)
			next_ptr = active_data_pointer - 16'h0001; // see RQ11
		else if (ptr_op.inc)
			next_ptr = active_data_pointer + 16'h0001;
		else
			ptr_upd = 1'b0;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pointer_a_low <= `SFRC_RST_ZERO;
			pointer_a_high <= `SFRC_RST_ZERO;
			pointer_b_low <= `SFRC_RST_ZERO;
			pointer_b_high <= `SFRC_RST_ZERO;
			pointer_select <= `SFRC_RST_ZERO;
		end else begin
			if (ptr_upd && cpu_clock_en) begin
				if (use_b) begin // see RQ8
					pointer_b_high <= next_ptr[15:8];
					pointer_b_low <= next_ptr[7:0];
				end else begin
					pointer_a_high <= next_ptr[15:8];
					pointer_a_low <= next_ptr[7:0];
				end
			end else if (wr_en) begin
				unique case (sfr_req.addr)
					`SFRC_ADDR_PTR_A_LOW: pointer_a_low <= wr_byte;
					`SFRC_ADDR_PTR_A_HIGH: pointer_a_high <= wr_byte;
					`SFRC_ADDR_PTR_B_LOW: pointer_b_low <= wr_byte; // see RQ10
					`SFRC_ADDR_PTR_B_HIGH: pointer_b_high <= wr_byte; // see RQ10
					`SFRC_ADDR_PTR_SELECT:
						pointer_select <= wr_byte & `SFRC_PSEL_IMPL; // see RQ9
					default: ;
				endcase
			end
		end
	end

	// Power control: a software write wins over a wake in the same cycle
	logic pctl_wr;
	assign pctl_wr = wr_en && sfr_req.addr == `SFRC_ADDR_POWER_CTL;

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			power_control <= `SFRC_RST_ZERO;
		else if (pctl_wr)
			power_control <= wr_byte & `SFRC_PCTL_IMPL; // see RQ14
		else if (wake_event) begin
			power_control[`SFRC_PCTL_POWER_DOWN] <= 1'b0;
			power_control[`SFRC_PCTL_IDLE] <= 1'b0;
		end
	end

	assign baud_double = power_control[`SFRC_PCTL_BAUD_DOUBLE]; // see RQ12
	assign frame_error_select =
		power_control[`SFRC_PCTL_FRAME_ERR]; // see RQ13
	assign power_down_active =
		power_control[`SFRC_PCTL_POWER_DOWN]; // see RQ15
	assign idle_active = power_control[`SFRC_PCTL_IDLE] &&
		!power_down_active; // see RQ21

	// Economy divider
	sfrc_eco_t eco_mode;
	logic [9:0] eco_cnt;
	logic [9:0] eco_last;
	logic eco_tick;

	assign eco_mode = sfrc_eco_t'(
		power_management_reg[`SFRC_PMGT_ECO_LSB +: 2]);

	always_comb begin
		unique case (eco_mode)
			SFRC_ECO_OFF: eco_last = 10'h000;
			SFRC_ECO_DIV4: eco_last = 10'(`SFRC_ECO_DIV_A - 1);
			SFRC_ECO_DIV64: eco_last = 10'(`SFRC_ECO_DIV_B - 1);
			SFRC_ECO_DIV1024: eco_last = 10'(`SFRC_ECO_DIV_C - 1);
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			eco_cnt <= 10'h000;
		else if (power_down_active || eco_cnt >= eco_last)
			eco_cnt <= 10'h000;
		else
			eco_cnt <= eco_cnt + 10'h001; // see RQ17
	end

	assign eco_tick = (eco_cnt >= eco_last); // see RQ17
	assign periph_clock_en = eco_tick && !power_down_active; // see RQ15
	assign cpu_clock_en = periph_clock_en &&
		!power_control[`SFRC_PCTL_IDLE]; // see RQ16

	// Data-space access steering; this array is apart from the scratchpad
	logic [7:0] sram [SRAM_BYTES]; // see RQ18
	logic sram_en;
	sfrc_mstate_t mstate;
	logic [4:0] mcnt;
	logic [SRAM_AW-1:0] sram_idx;

	assign sram_en = power_management_reg[`SFRC_PMGT_SRAM_EN]; // see RQ4
	assign mem_onchip = sram_en &&
		mem_req.addr <= `SFRC_ONCHIP_TOP; // see RQ1 RQ2 RQ3
	assign sram_idx = mem_req.addr[SRAM_AW-1:0];

	always_ff @(posedge clock) begin
		if (mstate == SFRC_M_IDLE && mem_req.req && mem_onchip &&
			mem_req.we)
			sram[sram_idx] <= mem_req.wdata; // see RQ1
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mstate <= SFRC_M_IDLE;
			mcnt <= 5'h00;
			mem_done <= 1'b0;
			mem_rdata <= `SFRC_RST_ZERO;
			ext_req <= '0;
		end else begin
			mem_done <= 1'b0;
			unique case (mstate)
				SFRC_M_IDLE: begin
					mcnt <= 5'h00;
					if (mem_req.req && mem_onchip) begin
						mem_rdata <= sram[sram_idx];
						mstate <= SFRC_M_ONCHIP;
					end else if (mem_req.req) begin
						ext_req <= mem_req; // see RQ2 RQ3
						mstate <= SFRC_M_EXTERN;
					end
				end
				SFRC_M_ONCHIP: begin
					if (eco_tick)
						mcnt <= mcnt + 5'h01;
					if (eco_tick && mcnt == ONCHIP_CLKS - 5'h02) begin
						mem_done <= 1'b1; // see RQ20
						mstate <= SFRC_M_IDLE;
					end
				end
				SFRC_M_EXTERN: begin
					if (ext_done) begin
						ext_req.req <= 1'b0;
						mem_rdata <= ext_req.we ? mem_rdata : ext_rdata;
						mem_done <= 1'b1;
						mstate <= SFRC_M_IDLE;
					end
				end
				default: mstate <= SFRC_M_IDLE;
			endcase
		end
	end
endmodule : sfrc_core
`default_nettype wire

// ---- logic/sfrc_cfg.svh ----
`ifndef SFRC_CFG_SVH
`define SFRC_CFG_SVH

// Register offsets
`define SFRC_ADDR_PORT0 8'h80
`define SFRC_ADDR_STACK 8'h81
`define SFRC_ADDR_PTR_A_LOW 8'h82
`define SFRC_ADDR_PTR_A_HIGH 8'h83
`define SFRC_ADDR_PTR_B_LOW 8'h84
`define SFRC_ADDR_PTR_B_HIGH 8'h85
`define SFRC_ADDR_PTR_SELECT 8'h86
`define SFRC_ADDR_POWER_CTL 8'h87
`define SFRC_ADDR_TIMER_CTL 8'h88
`define SFRC_ADDR_PORT4_CSIN 8'hA2
`define SFRC_ADDR_POWER_MGMT 8'hC4

// Field positions
`define SFRC_PCTL_BAUD_DOUBLE 7
`define SFRC_PCTL_FRAME_ERR 6
`define SFRC_PCTL_FLAG_HIGH 3
`define SFRC_PCTL_FLAG_LOW 2
`define SFRC_PCTL_POWER_DOWN 1
`define SFRC_PCTL_IDLE 0
`define SFRC_PMGT_SRAM_EN 0
`define SFRC_PMGT_ECO_LSB 6
`define SFRC_P4CS_PULLUP 0
`define SFRC_PSEL_BIT 0

// Implemented-bit masks; other bits read as one, except select bits 1-7, which read as zero
`define SFRC_PCTL_IMPL 8'hCF
`define SFRC_PMGT_IMPL 8'hC1
`define SFRC_P4CS_IMPL 8'h01
`define SFRC_PSEL_IMPL 8'h01

// Reset values
`define SFRC_RST_PORT0 8'hFF
`define SFRC_RST_STACK 8'h07
`define SFRC_RST_ZERO 8'h00

// Address space and timing
`define SFRC_SFR_SPACE_MSB 7
`define SFRC_ONCHIP_TOP 16'h03FF
`define SFRC_CLKS_PER_MC 4
`define SFRC_ONCHIP_MC 2
`define SFRC_ECO_DIV_A 4
`define SFRC_ECO_DIV_B 64
`define SFRC_ECO_DIV_C 1024
`define SFRC_OPC_PTR_DEC 8'hA5
`define SFRC_UNIMPL_BYTE 8'hFF

`endif

// ---- logic/sfrc_pkg.sv ----
`default_nettype none
package sfrc_pkg;
	typedef enum logic [1:0] {
		SFRC_ECO_OFF,
		SFRC_ECO_DIV4,
		SFRC_ECO_DIV64,
		SFRC_ECO_DIV1024
	} sfrc_eco_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic direct;
		logic bit_op;
		logic [2:0] bit_sel;
	} sfrc_sfr_req_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} sfrc_mem_req_t;

	typedef struct packed {
		logic load;
		logic inc;
		logic [15:0] value;
		logic op_valid;
		logic [7:0] opcode;
	} sfrc_ptr_op_t;
endpackage : sfrc_pkg
`default_nettype wire

// ---- tb/sfrc_core_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfrc_core_checker
	import sfrc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire sfrc_sfr_req_t sfr_req,
	input wire logic sfr_other_hit,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic sfr_bit_ok,
	input wire sfrc_ptr_op_t ptr_op,
	input wire logic [15:0] active_data_pointer,
	input wire sfrc_mem_req_t mem_req,
	input wire logic mem_onchip,
	input wire logic mem_done,
	input wire sfrc_mem_req_t ext_req,
	input wire logic ext_done,
	input wire logic cpu_clock_en,
	input wire logic periph_clock_en,
	input wire logic power_down_active,
	input wire logic idle_active,
	input wire logic baud_double,
	input wire logic frame_error_select
);
	logic busy;
	logic take;
	logic rd_at;
	assign take = mem_req.req && (!busy || mem_done);
	assign rd_at = sfr_req.rd && sfr_req.direct;
	// Tracks the data-space engine so takes are seen as the design sees them
	always_ff @(posedge clock or posedge rst) begin
		if (rst)
			busy <= 1'b0;
		else
			busy <= take || (busy && !mem_done);
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	sequence s_take_on; take && mem_onchip; endsequence
	sequence s_ticks; periph_clock_en [*8]; endsequence
	property p_onchip_early; s_take_on |=> !mem_done [*7]; endproperty
	a_onchip_early: assert property (p_onchip_early)
		else $error("on-chip access done early");
	property p_onchip_late; s_take_on ##1 s_ticks |-> mem_done; endproperty
	a_onchip_late: assert property (p_onchip_late)
		else $error("on-chip access done late");
	property p_high_ext; mem_req.addr > 16'h03FF |-> !mem_onchip; endproperty
	a_high_ext: assert property (p_high_ext)
		else $error("high address kept on chip");
	property p_ext_rise;
		$rose(ext_req.req) |-> $past(take) && !$past(mem_onchip);
	endproperty
	a_ext_rise: assert property (p_ext_rise)
		else $error("external request without external take");
	property p_ext_done;
		ext_req.req && ext_done |=> mem_done && !ext_req.req;
	endproperty
	a_ext_done: assert property (p_ext_done)
		else $error("external completion mishandled");
	property p_indirect;
		sfr_req.rd && !sfr_req.direct |-> sfr_rdata == 8'h00 && !sfr_hit;
	endproperty
	a_indirect: assert property (p_indirect)
		else $error("indirect access reached a register");
	property p_bit_ok;
		sfr_req.direct && sfr_req.addr[7]
			|-> sfr_bit_ok == (sfr_req.addr[2:0] == 3'h0);
	endproperty
	a_bit_ok: assert property (p_bit_ok)
		else $error("bit access flag wrong");
	property p_unimpl;
		rd_at && sfr_req.addr == 8'h8F && !sfr_other_hit
			|-> sfr_rdata == 8'hFF;
	endproperty
	a_unimpl: assert property (p_unimpl)
		else $error("empty address not read high");
	property p_sel_res;
		rd_at && sfr_req.addr == 8'h86 |-> sfr_rdata[7:1] == 7'h00;
	endproperty
	a_sel_res: assert property (p_sel_res)
		else $error("select reserved bits not zero");
	property p_dec;
		ptr_op.op_valid && ptr_op.opcode == 8'hA5 && !ptr_op.load
			&& cpu_clock_en && !sfr_req.wr |=> active_data_pointer
			== $past(active_data_pointer) - 16'h0001;
	endproperty
	a_dec: assert property (p_dec)
		else $error("pointer not decremented");
	property p_sleep;
		power_down_active |-> !cpu_clock_en && !periph_clock_en
			&& !idle_active;
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("clocks run in power-down");
	property p_idle; idle_active |-> !cpu_clock_en; endproperty
	a_idle: assert property (p_idle)
		else $error("cpu clock runs in idle");
	property p_pctl;
		sfr_req.wr && sfr_req.direct && !sfr_req.bit_op
			&& sfr_req.addr == 8'h87 |=> baud_double
			== $past(sfr_req.wdata[7]) && frame_error_select
			== $past(sfr_req.wdata[6]);
	endproperty
	a_pctl: assert property (p_pctl)
		else $error("serial mode bits not taken");
endmodule : sfrc_core_checker
bind sfrc_core sfrc_core_checker chk_u (.clock, .rst, .sfr_req,
	.sfr_other_hit, .sfr_rdata, .sfr_hit, .sfr_bit_ok, .ptr_op,
	.active_data_pointer, .mem_req, .mem_onchip, .mem_done, .ext_req,
	.ext_done, .cpu_clock_en, .periph_clock_en, .power_down_active,
	.idle_active, .baud_double, .frame_error_select);
`default_nettype wire

// ---- tb/sfrc_ext_bus_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module sfrc_ext_bus_model
	import sfrc_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire sfrc_mem_req_t ext_req,
	input wire logic [3:0] ext_delay,
	output logic ext_done,
	output logic [7:0] ext_rdata
);
	logic [3:0] wait_cnt;
	// Answers ext_delay plus one cycles after the request with the address low byte xor 5A
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wait_cnt <= 4'h0;
			ext_done <= 1'b0;
			ext_rdata <= 8'h00;
		end else begin
			ext_done <= 1'b0;
			if (ext_req.req && !ext_done) begin
				wait_cnt <= wait_cnt + 4'h1;
				if (wait_cnt == ext_delay) begin
					wait_cnt <= 4'h0;
					ext_done <= 1'b1;
					ext_rdata <= ext_req.addr[7:0] ^ 8'h5A;
				end
			end else begin
				// Released bus inverts its last value every cycle
				ext_rdata <= ~ext_rdata;
			end
		end
	end
endmodule : sfrc_ext_bus_model
`default_nettype wire

// ---- tb/test_sfr_core_active_data_pointer_power_memmap.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, g); end end
module test_sfr_core_active_data_pointer_power_memmap
	import sfrc_pkg::*;
;
	logic clock = 1'b0;
	logic rst = 1'b1;
	sfrc_sfr_req_t sfr_req = '0;
	sfrc_ptr_op_t ptr_op = '0;
	sfrc_mem_req_t mem_req = '0;
	sfrc_mem_req_t ext_req;
	logic wake_event = 1'b0;
	logic [3:0] ext_delay = 4'h0;
	logic [7:0] sfr_rdata, mem_rdata, ext_rdata, port0_latch_q;
	logic [7:0] stack_pointer_q, timer_control_q, sv, mv, v, hb;
	logic [15:0] active_data_pointer;
	logic sfr_hit, sfr_bit_ok, mem_onchip, mem_done, ext_done;
	logic cpu_clock_en, periph_clock_en, power_down_active, idle_active;
	logic baud_double, frame_error_select, port0_pullup_enable;
	logic [7:0] sq[$];
	logic [7:0] mq[$];
	int n_errors = 0;
	int checks = 0;
	int seed = 9158;
	int cycles = 0;
	int cnt;
	int divs[3] = '{4, 64, 1024};
	sfrc_core dut_u (.clock, .rst, .sfr_req, .sfr_other_hit(1'b0),
		.sfr_other_rdata(8'h00), .sfr_rdata, .sfr_hit, .sfr_bit_ok, .ptr_op,
		.active_data_pointer, .mem_req, .mem_onchip, .mem_done, .mem_rdata,
		.ext_req, .ext_done, .ext_rdata, .wake_event, .cpu_clock_en,
		.periph_clock_en, .power_down_active, .idle_active, .baud_double,
		.frame_error_select, .port0_pullup_enable, .port0_latch_q,
		.stack_pointer_q, .timer_control_q);
	sfrc_ext_bus_model bus_u (.clock, .rst, .ext_req, .ext_delay,
		.ext_done, .ext_rdata);
	initial forever #2 clock = ~clock;
	task automatic tally_and_finish();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			tally_and_finish();
		end
		if (sfr_req.rd && sq.size() > 0) begin
			sv = sq.pop_front();
			`CHK("sfr_rdata", sv, sfr_rdata)
		end
		if (mem_done === 1'b1 && mq.size() > 0) begin
			mv = mq.pop_front();
			`CHK("mem_rdata", mv, mem_rdata)
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d,
		input logic b = 1'b0, input logic [2:0] s = 3'h0);
		@(posedge clock) sfr_req <= {a, d, 1'b0, 1'b1, 1'b1, b, s};
		@(posedge clock) sfr_req <= '0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic dr = 1'b1);
		@(posedge clock) sfr_req <= {a, 8'h00, 1'b1, 1'b0, dr, 4'h0};
		sq.push_back(e);
		@(posedge clock) sfr_req <= '0;
		#1;
	endtask : rd
	task automatic mem(input logic [15:0] a, input logic we,
		input logic [7:0] d, input logic on, input logic [7:0] e);
		int i;
		@(posedge clock) mem_req <= {1'b1, we, a, d};
		#1 `CHK("mem_onchip", on, mem_onchip)
		// Noted at the take edge so an earlier completion cannot pop it
		@(posedge clock) mem_req <= '0;
		if (!we)
			mq.push_back(e);
		i = 0;
		#1;
		while (mem_done !== 1'b1 && i < 60) begin
			@(posedge clock);
			#1 i++;
		end
		if (i == 60)
			n_errors++;
	endtask : mem
	task automatic wake();
		@(posedge clock) wake_event <= 1'b1;
		@(posedge clock) wake_event <= 1'b0;
		#1 `CHK("asleep", 1'b0, power_down_active | idle_active)
	endtask : wake
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		hb = 8'($random(seed));
		rd(8'h80, 8'hFF);
		rd(8'h81, 8'h07);
		`CHK("port0_q", 8'hFF, port0_latch_q)
		`CHK("stack_q", 8'h07, stack_pointer_q)
		rd(8'h87, 8'h30);
		rd(8'hC4, 8'h3E);
		rd(8'hA2, 8'hFE);
		rd(8'h8F, 8'hFF);
		rd(8'h82, 8'h00, 1'b0);
		rd(8'h40, 8'h00);
		mem(16'h0010, 1'b0, 8'h00, 1'b0, 8'h4A);
		wr(8'h82, 8'h34);
		wr(8'h83, 8'h12);
		wr(8'h84, 8'h00);
		wr(8'h85, hb);
		rd(8'h85, hb);
		`CHK("pointer", 16'h1234, active_data_pointer)
		wr(8'h86, 8'hFF);
		rd(8'h86, 8'h01);
		@(posedge clock) ptr_op <= {18'h00000, 1'b1, 8'hA5};
		@(posedge clock) ptr_op <= '0;
		#1 `CHK("pointer", {hb, 8'h00} - 16'h0001, active_data_pointer)
		rd(8'h84, 8'hFF);
		wr(8'h86, 8'h00);
		`CHK("pointer", 16'h1234, active_data_pointer)
		wr(8'h87, 8'hCC);
		rd(8'h87, 8'hFC);
		`CHK("baud", 1'b1, baud_double)
		`CHK("frame", 1'b1, frame_error_select)
		wr(8'h87, 8'h03);
		`CHK("pd", 1'b1, power_down_active)
		`CHK("idle", 1'b0, idle_active)
		`CHK("periph", 1'b0, periph_clock_en)
		wake();
		wr(8'h87, 8'h01);
		`CHK("idle", 1'b1, idle_active)
		`CHK("cpu", 1'b0, cpu_clock_en)
		`CHK("periph", 1'b1, periph_clock_en)
		wake();
		wr(8'h88, 8'h01, 1'b1, 3'h3);
		`CHK("timer_ctl", 8'h08, timer_control_q)
		wr(8'h87, 8'h01, 1'b1, 3'h7);
		`CHK("baud", 1'b0, baud_double)
		wr(8'hA2, 8'h01);
		`CHK("pullup", 1'b1, port0_pullup_enable)
		wr(8'hA2, 8'h00);
		`CHK("pullup", 1'b0, port0_pullup_enable)
		for (int k = 0; k < 3; k++) begin
			v = 8'(k + 1) << 6;
			wr(8'hC4, v);
			repeat (divs[k]) @(posedge clock);
			cnt = 0;
			repeat (2 * divs[k]) @(posedge clock) cnt += periph_clock_en;
			`CHK("ticks", 2, cnt)
		end
		wr(8'hC4, 8'h01);
		rd(8'hC4, 8'h3F);
		v = 8'($random(seed));
		mem(16'h03FF, 1'b1, v, 1'b1, 8'h00);
		mem(16'h03FF, 1'b0, 8'h00, 1'b1, v);
		@(posedge clock) ext_delay <= 4'h5;
		mem(16'h0400, 1'b0, 8'h00, 1'b0, 8'h5A);
		mem(16'hFFFF, 1'b0, 8'h00, 1'b0, 8'hA5);
		tally_and_finish();
	end
endmodule : test_sfr_core_active_data_pointer_power_memmap
`default_nettype wire
